/* hw/escm_pkg.sv */
// shared constants, types and checksum helpers for the sensor command block
// Notes on behaviour
// - powers up idle; full sampling starts on 0x0021
// - 0x0037 samples climate and gas, particles off
// - 0x0104 stops sampling, back to idle
// - ready read returns 0x00, flag, checksum
// - measured-value command clears the ready flag
// - sampling refreshes values each second, sets flag
// - value read always returns the latest values
// - host waits before reading measured-value frame
// - particle words read 0xffff in gas-only state
// - frame starts with four particle words, checksummed
// - then humidity and compensated temperature words
// - then gas indices; 24 bytes in total
// - temperature plus slope times temperature plus offset
// - new slope and offset applied first-order smoothed
// - compensation frame: offset, slope, time constant
// - warm-start word, default cold, 65535 fully warm
// - warm-start applied only at next sampling start
// - each data word followed by crc-8, poly 0x31
// - target address 0x69, 100 kbit/s, no stretching
// - command code is sent without a checksum
package escm_pkg;
    localparam logic [6:0] I2C_ADDR = 7'h69;
    localparam logic [15:0] CMD_START = 16'h0021;
    localparam logic [15:0] CMD_START_GAS = 16'h0037;
    localparam logic [15:0] CMD_STOP = 16'h0104;
    localparam logic [15:0] CMD_READY = 16'h0202;
    localparam logic [15:0] CMD_VALUES = 16'h03c4;
    localparam logic [15:0] CMD_TCOMP = 16'h60b2;
    localparam logic [15:0] CMD_WARM = 16'h60c6;
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hff;
    localparam logic [15:0] UNKNOWN = 16'hffff;
    localparam logic [15:0] TCOMP_RST = 16'h0000;
    localparam logic [15:0] WARM_RST = 16'h0000;
    localparam int SLOPE_SCALE = 10000;
    localparam int CLK_HZ = 10_000_000;
    localparam int I2C_HZ = 100_000;
    localparam int BIT_CYC = CLK_HZ / I2C_HZ;
    localparam int QTR_CYC = BIT_CYC / 4;
    localparam int SAMPLE_MS = 1000;
    localparam int SAMPLE_CYC = CLK_HZ / 1000 * SAMPLE_MS;
    localparam int READ_WAIT_MS = 20;
    localparam int READ_WAIT_CYC = CLK_HZ / 1000 * READ_WAIT_MS;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_FULL = 2'b01,
        climate_gas_only_state = 2'b10
    } escm_mode_t;

    // msb-first crc-8 over one big-endian word
    function automatic logic [7:0] escm_crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    // byte 0 high, byte 1 low, byte 2 checksum of a framed word
    function automatic logic [7:0] escm_frame_byte(input logic [15:0] w, input logic [1:0] pos);
        return (pos == 2'd0) ? w[15:8] : (pos == 2'd1) ? w[7:0] : escm_crc8(w);
    endfunction
endpackage

/* hw/escm_i2c_if.sv */
// open-drain two-wire link joining the host and device ends
`timescale 1ns/1ps
`default_nettype none
interface escm_i2c_if;
    logic scl_o;
    logic scl_oe_n;
    logic h_sda_o;
    logic h_sda_oe_n;
    logic d_sda_o;
    logic d_sda_oe_n;
    logic scl;
    logic sda;

    // wired-and with pull-ups: a line is low while any enabled driver pulls it low
    assign scl = !(!scl_oe_n && !scl_o);
    assign sda = !((!h_sda_oe_n && !h_sda_o) || (!d_sda_oe_n && !d_sda_o));

    modport host (output scl_o, output scl_oe_n, output h_sda_o, output h_sda_oe_n, input scl, input sda);
    modport dev (output d_sda_o, output d_sda_oe_n, input scl, input sda);
endinterface
`default_nettype wire

/* hw/escm_dev.sv */
// device end: two-wire target, command decode, sampling and temperature compensation
`timescale 1ns/1ps
`default_nettype none
module escm_dev
    import escm_pkg::*;
#(
    parameter int SAMPLE_CYC_P = SAMPLE_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    escm_i2c_if.dev bus,
    input wire logic [3:0][15:0] pm_raw,
    input wire logic [15:0] hum_raw,
    input wire logic [15:0] temp_raw,
    input wire logic [15:0] voc_raw,
    input wire logic [15:0] nox_raw,
    output var escm_mode_t mode,
    output logic particle_on,
    output logic data_ready,
    output logic [15:0] warm_applied
);
    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_ADDR = 3'b001,
        D_RX = 3'b010,
        D_ACK = 3'b011,
        D_TX = 3'b100,
        D_MACK = 3'b101
    } escm_dst_t;

    typedef struct packed {
        logic [2:0] scl_p;
        logic [2:0] sda_p;
        escm_dst_t st;
        logic [7:0] sh;
        logic [3:0] bitn;
        logic rnw;
        logic [1:0] rxc;
        logic cmd_new;
        logic bad;
        logic [2:0] wi;
        logic [1:0] pos;
        logic [7:0] hold;
        logic [15:0] cmd;
        logic [2:0][15:0] wbuf;
        logic drive;
        escm_mode_t mode;
        logic ready;
        logic [23:0] tick;
        logic [7:0][15:0] vals;
        logic [15:0] off_tgt;
        logic [15:0] slope_tgt;
        logic [15:0] tau;
        logic [15:0] off_eff;
        logic [15:0] slope_eff;
        logic [15:0] warm;
        logic [15:0] warm_app;
    } escm_dstate_t;

    escm_dstate_t r_q;
    escm_dstate_t r_d;
    logic scl_hi;
    logic start_c;
    logic stop_c;
    logic rise;
    logic fall;
    logic [15:0] tw;
    logic [7:0] tb;
    logic signed [31:0] t32;
    logic signed [31:0] tc;
    // word, byte position step: three bytes per framed word
    function automatic logic [4:0] adv(input logic [2:0] wi, input logic [1:0] pos);
        return (pos == 2'd2) ? {wi + 3'd1, 2'd0} : {wi, pos + 2'd1};
    endfunction
    // one first-order step per second; integer division leaves a residue below tau
    function automatic logic [15:0] smooth(input logic [15:0] eff, input logic [15:0] tgt,
                                           input logic [15:0] tau);
        logic signed [31:0] d;
        d = 32'(signed'(tgt)) - 32'(signed'(eff));
        if (tau != 16'h0000) d = d / $signed({16'h0000, tau});
        return 16'(32'(signed'(eff)) + d);
    endfunction
    // word answered for the current read position of the pending command
    function automatic logic [15:0] resp_word(input escm_dstate_t s);
        logic [15:0] w;
        w = UNKNOWN;
        case (s.cmd)
            CMD_READY: if (s.wi == 3'd0) w = {15'h0000, s.ready};
            CMD_VALUES: w = s.vals[s.wi];
            CMD_TCOMP: begin
                if (s.wi == 3'd0) w = s.off_tgt;
                else if (s.wi == 3'd1) w = s.slope_tgt;
                else if (s.wi == 3'd2) w = s.tau;
            end
            CMD_WARM: if (s.wi == 3'd0) w = s.warm;
            default: w = UNKNOWN;
        endcase
        return w;
    endfunction
    always_comb begin
        r_d = r_q;
        r_d.scl_p = {r_q.scl_p[1:0], bus.scl};
        r_d.sda_p = {r_q.sda_p[1:0], bus.sda};
        // edges judged on the second and third stages only
        scl_hi = r_q.scl_p[1] & r_q.scl_p[2];
        start_c = scl_hi & r_q.sda_p[2] & ~r_q.sda_p[1];
        stop_c = scl_hi & ~r_q.sda_p[2] & r_q.sda_p[1];
        rise = r_q.scl_p[1] & ~r_q.scl_p[2];
        fall = ~r_q.scl_p[1] & r_q.scl_p[2];
        tw = resp_word(r_q);
        tb = escm_frame_byte(tw, r_q.pos);
        t32 = 32'(signed'(temp_raw));
        tc = t32 + (t32 * 32'(signed'(r_q.slope_eff))) / SLOPE_SCALE + 32'(signed'(r_q.off_eff));
        // a finished write transaction runs its command at stop or repeated start
        if ((start_c || stop_c) && !r_q.rnw && r_q.cmd_new) begin
            r_d.cmd_new = 1'b0;
            case (r_q.cmd)
                CMD_START: begin
                    r_d.mode = MODE_FULL;
                    r_d.warm_app = r_q.warm;
                end
                CMD_START_GAS: begin
                    r_d.mode = climate_gas_only_state;
                    r_d.warm_app = r_q.warm;
                end
                CMD_STOP: begin
                    r_d.mode = MODE_IDLE;
                    r_d.tick = '0;
                    r_d.ready = 1'b0;
                end
                CMD_VALUES: r_d.ready = 1'b0;
                CMD_TCOMP: begin
                    // all three words with good checksums, or nothing changes
                    if (r_q.wi == 3'd3 && !r_q.bad) begin
                        r_d.off_tgt = r_q.wbuf[0];
                        r_d.slope_tgt = r_q.wbuf[1];
                        r_d.tau = r_q.wbuf[2];
                    end
                end
                CMD_WARM: begin
                    if (r_q.wi == 3'd1 && !r_q.bad) r_d.warm = r_q.wbuf[0];
                end
                default: r_d.cmd_new = 1'b0;
            endcase
        end
        // target bit engine: sample on scl rise, change sda after scl fall, never stretch
        if (start_c) begin
            r_d.st = D_ADDR;
            r_d.bitn = '0;
            r_d.rxc = '0;
            r_d.wi = '0;
            r_d.pos = '0;
            r_d.bad = 1'b0;
            r_d.drive = 1'b0;
        end else if (stop_c) begin
            r_d.st = D_IDLE;
            r_d.drive = 1'b0;
        end else if (rise) begin
            if (r_q.st == D_ADDR || r_q.st == D_RX) begin
                r_d.sh = {r_q.sh[6:0], r_q.sda_p[1]};
                r_d.bitn = r_q.bitn + 4'd1;
            end else if (r_q.st == D_MACK && r_q.sda_p[1]) begin
                r_d.st = D_IDLE; // host nack ends the read
            end
        end else if (fall) begin
            unique case (r_q.st)
                D_IDLE: r_d.drive = 1'b0;
                D_ADDR: begin
                    if (r_q.bitn == 4'd8) begin
                        if (r_q.sh[7:1] == I2C_ADDR) begin
                            r_d.drive = 1'b1;
                            r_d.rnw = r_q.sh[0];
                            r_d.st = D_ACK;
                        end else begin
                            r_d.st = D_IDLE;
                        end
                    end
                end
                D_RX: begin
                    if (r_q.bitn == 4'd8) begin
                        r_d.drive = 1'b1;
                        r_d.st = D_ACK;
                        if (r_q.rxc != 2'd2) begin
                            // two bare command bytes, no checksum follows them
                            r_d.cmd = {r_q.cmd[7:0], r_q.sh};
                            r_d.rxc = r_q.rxc + 2'd1;
                            r_d.cmd_new = (r_q.rxc == 2'd1);
                        end else begin
                            {r_d.wi, r_d.pos} = adv(r_q.wi, r_q.pos);
                            if (r_q.pos == 2'd0) begin
                                r_d.hold = r_q.sh;
                            end else if (r_q.pos == 2'd1 && r_q.wi < 3'd3) begin
                                r_d.wbuf[r_q.wi[1:0]] = {r_q.hold, r_q.sh};
                            end else if (r_q.pos == 2'd2 && r_q.wi < 3'd3) begin
                                if (escm_crc8(r_q.wbuf[r_q.wi[1:0]]) != r_q.sh) r_d.bad = 1'b1;
                            end
                        end
                    end
                end
                D_ACK, D_MACK: begin
                    r_d.drive = 1'b0;
                    r_d.bitn = '0;
                    r_d.st = D_RX;
                    if (r_q.rnw) begin
                        r_d.sh = tb;
                        r_d.drive = ~tb[7];
                        r_d.bitn = 4'd1;
                        r_d.st = D_TX;
                        {r_d.wi, r_d.pos} = adv(r_q.wi, r_q.pos);
                    end
                end
                D_TX: begin
                    if (r_q.bitn == 4'd8) begin
                        r_d.drive = 1'b0;
                        r_d.st = D_MACK;
                    end else begin
                        r_d.sh = {r_q.sh[6:0], 1'b0};
                        r_d.drive = ~r_q.sh[6];
                        r_d.bitn = r_q.bitn + 4'd1;
                    end
                end
                default: r_d.st = D_IDLE;
            endcase
        end
        // once-a-second refresh on the next mode, so a stop ends the count; last so a sample beats a clear
        if (r_d.mode != MODE_IDLE) begin
            r_d.tick = r_q.tick + 24'd1;
            if (r_q.tick == 24'(SAMPLE_CYC_P - 1)) begin
                r_d.tick = '0;
                r_d.ready = 1'b1;
                for (int i = 0; i < 4; i++) begin
                    r_d.vals[i] = (r_d.mode == climate_gas_only_state) ? UNKNOWN : pm_raw[i];
                end
                r_d.vals[4] = hum_raw;
                r_d.vals[5] = (temp_raw == UNKNOWN) ? UNKNOWN : tc[15:0];
                r_d.vals[6] = voc_raw;
                r_d.vals[7] = nox_raw;
                r_d.off_eff = smooth(r_q.off_eff, r_q.off_tgt, r_q.tau);
                r_d.slope_eff = smooth(r_q.slope_eff, r_q.slope_tgt, r_q.tau);
            end
        end
        // values stay unknown until the first sample after a start
        if (srst) begin
            r_d = '0;
            r_d.scl_p = '1;
            r_d.sda_p = '1;
            r_d.mode = MODE_IDLE;
            r_d.vals = {8{UNKNOWN}};
            r_d.off_tgt = TCOMP_RST;
            r_d.slope_tgt = TCOMP_RST;
            r_d.tau = TCOMP_RST;
            r_d.off_eff = TCOMP_RST;
            r_d.slope_eff = TCOMP_RST;
            r_d.warm = WARM_RST;
            r_d.warm_app = WARM_RST;
        end
    end
    // reset acts even while the clock enable is low
    always_ff @(posedge clk) begin
        if (srst || ce) begin
            r_q <= r_d;
        end
    end
    assign bus.d_sda_o = 1'b0;
    assign bus.d_sda_oe_n = ~r_q.drive;
    assign mode = r_q.mode;
    assign particle_on = (r_q.mode == MODE_FULL);
    assign data_ready = r_q.ready;
    assign warm_applied = r_q.warm_app;
endmodule
`default_nettype wire

/* hw/escm_host.sv */
// host end: two-wire controller issuing commands and reading framed words
`timescale 1ns/1ps
`default_nettype none
module escm_host
    import escm_pkg::*;
#(
    parameter int READ_WAIT_CYC_P = READ_WAIT_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    escm_i2c_if.host bus,
    input wire logic req,
    input wire logic [15:0] cmd,
    input wire logic [1:0] wr_words,
    input wire logic [2:0][15:0] wdata,
    input wire logic [3:0] rd_words,
    output logic busy,
    output logic done,
    output logic nack_err,
    output logic crc_err,
    output logic [7:0][15:0] rdata
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_START = 3'b001,
        H_BIT = 3'b010,
        H_STOP = 3'b011,
        H_WAIT = 3'b100
    } escm_hst_t;

    typedef struct packed {
        logic [1:0] sda_p;
        escm_hst_t st;
        logic [4:0] qc;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [4:0] bi;
        logic rdph;
        logic [2:0] wi;
        logic [1:0] pos;
        logic [7:0] hold;
        logic [15:0] cmd;
        logic [1:0] nwr;
        logic [3:0] nrd;
        logic [2:0][15:0] wdata;
        logic [7:0][15:0] rdata;
        logic scl_low;
        logic sda_low;
        logic [17:0] wcnt;
        logic done;
        logic nack;
        logic crcerr;
    } escm_hstate_t;

    escm_hstate_t r_q;
    escm_hstate_t r_d;
    logic qend;
    logic txm;
    logic last;
    logic data_b;
    logic [2:0] nwi;
    logic [1:0] npos;
    logic [7:0] nxt;

    always_comb begin
        r_d = r_q;
        r_d.sda_p = {r_q.sda_p[0], bus.sda};
        r_d.done = 1'b0;
        qend = (r_q.qc == 5'(QTR_CYC - 1));
        // host sends on every byte except received data bytes
        txm = !(r_q.rdph && r_q.bi != 5'd0);
        last = r_q.rdph ? (r_q.bi == 5'(3 * r_q.nrd)) : (r_q.bi == 5'(2 + 3 * r_q.nwr));
        data_b = r_q.rdph ? (r_q.bi != 5'd0) : (r_q.bi > 5'd2);
        {nwi, npos} = data_b ? ((r_q.pos == 2'd2) ? {r_q.wi + 3'd1, 2'd0} : {r_q.wi, r_q.pos + 2'd1})
                             : {r_q.wi, r_q.pos};
        // command bytes go bare; data words carry their checksum
        nxt = (r_q.bi == 5'd0) ? r_q.cmd[15:8] :
              (r_q.bi == 5'd1) ? r_q.cmd[7:0] :
              escm_frame_byte(r_q.wdata[nwi[1:0]], npos);
        if (r_q.st != H_IDLE && r_q.st != H_WAIT) begin
            r_d.qc = qend ? 5'd0 : r_q.qc + 5'd1;
            r_d.ph = qend ? r_q.ph + 2'd1 : r_q.ph;
        end

        // four quarter-bit phases give 100 kbit/s at the link
        unique case (r_q.st)
            H_IDLE: begin
                if (req) begin
                    r_d.st = H_START;
                    r_d.cmd = cmd;
                    r_d.nwr = wr_words;
                    r_d.wdata = wdata;
                    r_d.nrd = rd_words;
                    r_d.rdph = 1'b0;
                    r_d.nack = 1'b0;
                    r_d.crcerr = 1'b0;
                    r_d.qc = '0;
                    r_d.ph = '0;
                end
            end
            H_START: begin
                if (qend && r_q.ph == 2'd1) r_d.sda_low = 1'b1;
                if (qend && r_q.ph == 2'd2) r_d.scl_low = 1'b1;
                if (qend && r_q.ph == 2'd3) begin
                    r_d.st = H_BIT;
                    r_d.bitn = '0;
                    r_d.bi = '0;
                    r_d.wi = '0;
                    r_d.pos = '0;
                    r_d.sh = {I2C_ADDR, r_q.rdph};
                end
            end
            H_BIT: begin
                if (qend && r_q.ph == 2'd0) begin
                    if (r_q.bitn != 4'd8) r_d.sda_low = txm & ~r_q.sh[7];
                    else r_d.sda_low = ~txm & ~last; // ack each read byte, nack the last
                end
                if (qend && r_q.ph == 2'd1) r_d.scl_low = 1'b0;
                if (qend && r_q.ph == 2'd2) begin
                    if (r_q.bitn != 4'd8) r_d.sh = {r_q.sh[6:0], r_q.sda_p[1]};
                    else if (txm && r_q.sda_p[1]) r_d.nack = 1'b1;
                end
                if (qend && r_q.ph == 2'd3) begin
                    r_d.scl_low = 1'b1;
                    r_d.bitn = r_q.bitn + 4'd1;
                    if (r_q.bitn == 4'd8) begin
                        r_d.bitn = '0;
                        r_d.wi = nwi;
                        r_d.pos = npos;
                        if (!txm) begin
                            if (r_q.pos == 2'd0) r_d.hold = r_q.sh;
                            else if (r_q.pos == 2'd1) r_d.rdata[r_q.wi] = {r_q.hold, r_q.sh};
                            else if (escm_crc8(r_q.rdata[r_q.wi]) != r_q.sh) r_d.crcerr = 1'b1;
                        end
                        if (r_q.nack || last) begin
                            r_d.st = H_STOP;
                        end else begin
                            r_d.bi = r_q.bi + 5'd1;
                            r_d.sh = nxt;
                        end
                    end
                end
            end
            H_STOP: begin
                if (qend && r_q.ph == 2'd0) r_d.sda_low = 1'b1;
                if (qend && r_q.ph == 2'd1) r_d.scl_low = 1'b0;
                if (qend && r_q.ph == 2'd2) r_d.sda_low = 1'b0;
                if (qend && r_q.ph == 2'd3) begin
                    if (!r_q.rdph && r_q.nrd != 4'd0 && !r_q.nack) begin
                        r_d.st = H_WAIT;
                        r_d.wcnt = '0;
                    end else begin
                        r_d.st = H_IDLE;
                        r_d.done = 1'b1;
                    end
                end
            end
            H_WAIT: begin
                // the device needs time to fill its buffers before the read header
                r_d.wcnt = r_q.wcnt + 18'd1;
                if (r_q.wcnt == 18'(READ_WAIT_CYC_P - 1)) begin
                    r_d.st = H_START;
                    r_d.rdph = 1'b1;
                    r_d.qc = '0;
                    r_d.ph = '0;
                end
            end
            default: r_d.st = H_IDLE;
        endcase

        if (srst) begin
            r_d = '0;
            r_d.sda_p = '1;
            r_d.st = H_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || ce) begin
            r_q <= r_d;
        end
    end

    // open drain: only ever pulls low, scl never released to the device
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe_n = ~r_q.scl_low;
    assign bus.h_sda_o = 1'b0;
    assign bus.h_sda_oe_n = ~r_q.sda_low;
    assign busy = (r_q.st != H_IDLE);
    assign done = r_q.done;
    assign nack_err = r_q.nack;
    assign crc_err = r_q.crcerr;
    assign rdata = r_q.rdata;
endmodule
`default_nettype wire

/* tb/escm_assertions.sv */
// checker for the link lines and the device mode outputs
`timescale 1ns/1ps
`default_nettype none
module escm_assertions
    import escm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sda,
    input wire logic d_sda_oe_n,
    input wire escm_mode_t mode,
    input wire logic particle_on,
    input wire logic data_ready,
    input wire logic [15:0] warm_applied
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // mode, warm word and a clearing of the flag only move once a stop has freed the bus; the flag may rise at any sample
    rst_state_a: assert property ($fell(srst) |-> mode == MODE_IDLE && !data_ready)
        else $error("not idle after reset");
    mode_at_stop_a: assert property ($changed(mode) |-> scl && sda)
        else $error("mode moved mid transfer");
    laser_on_a: assert property (particle_on == (mode == MODE_FULL))
        else $error("laser state wrong");
    idle_flag_a: assert property (mode == MODE_IDLE ##1 mode == MODE_IDLE |-> !data_ready)
        else $error("flag set while idle");
    flag_clear_a: assert property ($fell(data_ready) |-> scl && sda)
        else $error("flag cleared mid transfer");
    flag_rise_a: assert property ($rose(data_ready) |-> $past(mode) != MODE_IDLE)
        else $error("flag set without sampling");
    warm_start_a: assert property ($changed(warm_applied) |-> mode != MODE_IDLE && scl && sda)
        else $error("warm word taken outside a start");
    sda_turn_a: assert property ($changed(d_sda_oe_n) |-> !scl)
        else $error("device moved data while clock high");
    full_c: cover property (mode == MODE_FULL);
    gas_c: cover property (mode == climate_gas_only_state);
    ready_c: cover property ($rose(data_ready));
    clear_c: cover property ($fell(data_ready));
endmodule
`default_nettype wire

/* tb/env_sensor_cmd_measure_ctrl_tb_top.sv */
// bench driving host and device ends joined by the link
`timescale 1ns/1ps
`default_nettype none
module env_sensor_cmd_measure_ctrl_tb_top
    import escm_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic req = 1'b0;
    logic [15:0] cmd = 16'h0000;
    logic [1:0] wr_words = 2'h0;
    logic [2:0][15:0] wdata = '0;
    logic [3:0] rd_words = 4'h0;
    logic [3:0][15:0] pm = {16'h0028, 16'h001e, 16'h0014, 16'h000a};
    logic [15:0] hum = 16'h1388;
    logic [15:0] temp = 16'h0fa0;
    logic [15:0] voc = 16'h0064;
    logic [15:0] nox = 16'h000a;
    logic busy, done, nack_err, crc_err, particle_on, data_ready;
    logic [7:0][15:0] rdata;
    logic [15:0] warm_applied;
    escm_mode_t mode;
    int mismatches = 0;
    int total_checks = 0;
    escm_i2c_if bus ();
    // short sample period keeps the run brief
    escm_dev #(.SAMPLE_CYC_P(1000)) u_escm_dev (.clk(clk), .srst(srst), .ce(ce), .bus(bus), .pm_raw(pm),
        .hum_raw(hum), .temp_raw(temp), .voc_raw(voc), .nox_raw(nox), .mode(mode), .particle_on(particle_on),
        .data_ready(data_ready), .warm_applied(warm_applied));
    escm_host #(.READ_WAIT_CYC_P(300)) u_escm_host (.clk(clk), .srst(srst), .ce(ce), .bus(bus), .req(req),
        .cmd(cmd), .wr_words(wr_words), .wdata(wdata), .rd_words(rd_words), .busy(busy), .done(done),
        .nack_err(nack_err), .crc_err(crc_err), .rdata(rdata));
    escm_assertions u_escm_assertions (.clk(clk), .srst(srst), .scl(bus.scl), .sda(bus.sda),
        .d_sda_oe_n(bus.d_sda_oe_n), .mode(mode), .particle_on(particle_on), .data_ready(data_ready),
        .warm_applied(warm_applied));
    // 100 ns clock
    always #50 clk = ~clk;
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one command with optional words out and in; errors must stay clear
    task automatic xfer(input logic [15:0] c, input logic [1:0] nw, input logic [47:0] w, input logic [3:0] nr);
        int n;
        @(posedge clk);
        #1;
        req = 1'b1;
        cmd = c;
        wr_words = nw;
        wdata = w;
        rd_words = nr;
        @(posedge clk);
        #1;
        req = 1'b0;
        chk(busy, 1'b1);
        n = 0;
        while (done !== 1'b1 && n < 40000) begin
            @(posedge clk);
            #1;
            n++;
        end
        // a transfer that never finishes counts as a mismatch
        chk(done, 1'b1);
        chk({nack_err, crc_err}, 2'b00);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    initial begin
        #10000000;
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge clk);
        #1;
        srst = 1'b0;
        chk({mode, data_ready, warm_applied}, {MODE_IDLE, 1'b0, 16'h0000});
        $display("test reset done");
        xfer(CMD_TCOMP, 2'd3, {16'h0000, 16'h03e8, 16'h0064}, 4'd0);
        xfer(CMD_TCOMP, 2'd0, '0, 4'd3);
        chk(rdata[2:0], {16'h0000, 16'h03e8, 16'h0064});
        xfer(CMD_WARM, 2'd1, {32'h0, 16'hffff}, 4'd0);
        chk(warm_applied, 16'h0000);
        $display("test parameters done");
        xfer(CMD_START, 2'd0, '0, 4'd0);
        chk({mode, particle_on, warm_applied}, {MODE_FULL, 1'b1, 16'hffff});
        repeat (1100) @(posedge clk);
        #1;
        chk(data_ready, 1'b1);
        xfer(CMD_READY, 2'd0, '0, 4'd1);
        chk(rdata[0], 16'h0001);
        xfer(CMD_VALUES, 2'd0, '0, 4'd8);
        chk(rdata, {nox, voc, 16'h1194, hum, pm});
        $display("test full sampling done");
        xfer(CMD_STOP, 2'd0, '0, 4'd0);
        chk({mode, data_ready}, {MODE_IDLE, 1'b0});
        $display("test stop done");
        xfer(CMD_START_GAS, 2'd0, '0, 4'd0);
        chk({mode, particle_on}, {climate_gas_only_state, 1'b0});
        // a low enable freezes the sample counter, so no flag may appear meanwhile
        ce = 1'b0;
        repeat (1100) @(posedge clk);
        #1;
        chk(data_ready, 1'b0);
        ce = 1'b1;
        repeat (1100) @(posedge clk);
        xfer(CMD_VALUES, 2'd0, '0, 4'd6);
        chk(rdata[5:0], {16'h1194, hum, {4{UNKNOWN}}});
        $display("test gas only done");
        complete_run();
    end
endmodule
`default_nettype wire
